// file: msw_pkg.sv
package msw_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_WPROT = 8'h00;
  localparam logic [7:0] ADDR_FEED = 8'h04;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h10;
  localparam logic [7:0] ADDR_TMO_BASE = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h74;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h78;
  localparam logic [7:0] ADDR_BOOT = 8'h7c;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int NUM_WDT = 3;
  localparam int NUM_STAGE = 4;
  localparam int LP_IDX = 2;
  localparam logic [31:0] WPROT_KEY = 32'h5a5a_a5a5;
  localparam logic [31:0] TMO_RESET = 32'h0000_ffff;
  localparam logic [31:0] BOOT_PERIOD_RESET = 32'h0001_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // stage action codes
  typedef enum logic [2:0] {
    ACT_OFF = 3'h0,
    ACT_IRQ = 3'h1,
    ACT_CPU = 3'h2,
    ACT_CORE = 3'h3,
    ACT_SYS = 3'h4
  } msw_act_t;

  // reset pulses carried together
  typedef struct packed {
    logic sys;
    logic core;
    logic cpu;
  } msw_rst_t;

endpackage

// file: msw_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns

module msw_top
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // boot control
  input wire logic flash_boot,
  input wire logic boot_done,
  // write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // actions
  output logic irq,
  output logic cpu_rst,
  output logic core_rst,
  output logic sys_rst
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int NW = msw_pkg::NUM_WDT;
  localparam int NS = msw_pkg::NUM_STAGE;

  logic unlocked;
  logic [NW-1:0] wdt_en;
  logic [2:0] stage_act [NW][NS];
  logic [31:0] stage_tmo [NW][NS];
  logic [31:0] cnt [NW];
  logic [1:0] stage [NW];
  logic [NW-1:0] expire;
  logic [NW-1:0] feed;
  logic [NW-1:0] irq_stat;
  logic [NW-1:0] irq_mask;
  logic [31:0] boot_period;
  logic [31:0] boot_cnt;
  logic boot_busy;
  logic boot_init;
  msw_pkg::msw_rst_t next_rst;

  // write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;

  // merge byte lanes into an old word
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // address decoding used by both write and read paths
  function automatic logic addr_known(input logic [7:0] a);
    logic ok;
    ok = (a == msw_pkg::ADDR_WPROT) || (a == msw_pkg::ADDR_FEED)
      || (a == msw_pkg::ADDR_STATUS) || (a == msw_pkg::ADDR_IRQ_STAT)
      || (a == msw_pkg::ADDR_IRQ_MASK) || (a == msw_pkg::ADDR_BOOT)
      || (a >= msw_pkg::ADDR_CFG_BASE && a < 8'h10 + 8'(NW*NS*4))
      || (a >= msw_pkg::ADDR_TMO_BASE && a < 8'h40 + 8'(NW*NS*4));
    return ok && (a[1:0] == 2'h0);
  endfunction

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // accept address and data in either order, answer when both held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= msw_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr) ? msw_pkg::RESP_OKAY
                                           : msw_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // key unlocks, any other value locks again
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unlocked <= 1'b0;
    end
    else if (wr_go && aw_addr == msw_pkg::ADDR_WPROT)
    begin
      unlocked <= (w_data == msw_pkg::WPROT_KEY);
    end
  end

  // stage actions, timeouts, enables and boot period; locked writes drop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boot_init <= 1'b1;
      wdt_en <= '0;
      boot_period <= msw_pkg::BOOT_PERIOD_RESET;
      for (int w = 0; w < NW; w++)
      begin
        for (int s = 0; s < NS; s++)
        begin
          stage_act[w][s] <= msw_pkg::ACT_OFF;
          stage_tmo[w][s] <= msw_pkg::TMO_RESET;
        end
      end
    end
    else
    begin
      boot_init <= 1'b0;
      if (boot_init && flash_boot)
      begin
        wdt_en[msw_pkg::LP_IDX] <= 1'b1;
        wdt_en[0] <= 1'b1;
        stage_act[0][0] <= msw_pkg::ACT_CPU;
        stage_act[msw_pkg::LP_IDX][0] <= msw_pkg::ACT_SYS;
      end
      if (wr_go && unlocked)
      begin
        if (aw_addr == msw_pkg::ADDR_BOOT)
        begin
          boot_period <= strb_merge(boot_period, w_data, w_strb);
        end
        for (int w = 0; w < NW; w++)
        begin
          for (int s = 0; s < NS; s++)
          begin
            if (aw_addr == msw_pkg::ADDR_CFG_BASE + 8'((w*NS+s)*4))
            begin
              // bit 3 enables the instance, bits 2:0 select the action
              if (w_strb[0])
              begin
                wdt_en[w] <= w_data[3];
                if (w_data[2:0] == msw_pkg::ACT_SYS && w != msw_pkg::LP_IDX)
                begin
                  stage_act[w][s] <= msw_pkg::ACT_CORE;
                end
                else if (w_data[2:0] > msw_pkg::ACT_SYS)
                begin
                  stage_act[w][s] <= msw_pkg::ACT_OFF;
                end
                else
                begin
                  stage_act[w][s] <= w_data[2:0];
                end
              end
            end
            if (aw_addr == msw_pkg::ADDR_TMO_BASE + 8'((w*NS+s)*4))
            begin
              stage_tmo[w][s] <= strb_merge(stage_tmo[w][s], w_data,
                                            w_strb);
            end
          end
        end
      end
    end
  end

  // feed strobes: one bit per instance, not protected
  always_comb
  begin
    for (int w = 0; w < NW; w++)
    begin
      feed[w] = wr_go && aw_addr == msw_pkg::ADDR_FEED && w_data[w]
        && w_strb[0];
    end
  end

  // ---------------------------------------------------------------
  // watchdog stage engines
  // ---------------------------------------------------------------
  genvar gw;
  generate
    for (gw = 0; gw < NW; gw++)
    begin : g_wdt
      // expiry of the current stage
      assign expire[gw] = wdt_en[gw] && !feed[gw]
        && stage_act[gw][stage[gw]] != msw_pkg::ACT_OFF
        && cnt[gw] >= stage_tmo[gw][stage[gw]];

      // 32-bit counter walks through the stages
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cnt[gw] <= 32'h0000_0000;
          stage[gw] <= 2'h0;
        end
        else if (!wdt_en[gw] || feed[gw])
        begin
          cnt[gw] <= 32'h0000_0000;
          stage[gw] <= 2'h0;
        end
        else if (expire[gw] ||
                 stage_act[gw][stage[gw]] == msw_pkg::ACT_OFF)
        begin
          cnt[gw] <= 32'h0000_0000;
          stage[gw] <= stage[gw] + 2'h1;
        end
        else
        begin
          cnt[gw] <= cnt[gw] + 32'h0000_0001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // boot guard
  // ---------------------------------------------------------------
  // counts from a flash boot until boot_done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boot_busy <= 1'b0;
      boot_cnt <= 32'h0000_0000;
    end
    else if (boot_init)
    begin
      boot_busy <= flash_boot;
      boot_cnt <= 32'h0000_0000;
    end
    else if (boot_busy)
    begin
      boot_busy <= !boot_done;
      boot_cnt <= boot_cnt + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // actions and interrupt
  // ---------------------------------------------------------------
  // decode expiries into reset pulses
  always_comb
  begin
    next_rst = '0;
    for (int w = 0; w < NW; w++)
    begin
      if (expire[w])
      begin
        case (stage_act[w][stage[w]])
          msw_pkg::ACT_CPU: next_rst.cpu = 1'b1;
          msw_pkg::ACT_CORE: next_rst.core = 1'b1;
          msw_pkg::ACT_SYS: next_rst.sys = (w == msw_pkg::LP_IDX);
          default: ;
        endcase
      end
    end
    if (boot_busy && !boot_done && boot_cnt >= boot_period)
    begin
      next_rst.sys = 1'b1;
    end
  end

  // registered reset pulses; sys_rst stays high while the boot guard is overdue
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_rst <= 1'b0;
      core_rst <= 1'b0;
      sys_rst <= 1'b0;
    end
    else
    begin
      cpu_rst <= next_rst.cpu;
      core_rst <= next_rst.core;
      sys_rst <= next_rst.sys;
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      for (int w = 0; w < NW; w++)
      begin
        if (expire[w] && stage_act[w][stage[w]] == msw_pkg::ACT_IRQ)
        begin
          irq_stat[w] <= 1'b1;
        end
        else if (s_axi_arvalid && s_axi_arready
                 && s_axi_araddr == msw_pkg::ADDR_IRQ_STAT)
        begin
          irq_stat[w] <= 1'b0;
        end
      end
      if (wr_go && aw_addr == msw_pkg::ADDR_IRQ_MASK && w_strb[0])
      begin
        irq_mask <= w_data[NW-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= msw_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_known(s_axi_araddr) ? msw_pkg::RESP_OKAY
                                              : msw_pkg::RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr)
        msw_pkg::ADDR_WPROT: s_axi_rdata <= {31'h0, unlocked};
        msw_pkg::ADDR_STATUS:
          s_axi_rdata <= {21'h0, boot_busy, stage[2], stage[1], stage[0],
                          1'b0, wdt_en};
        msw_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
        msw_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
        msw_pkg::ADDR_BOOT: s_axi_rdata <= boot_period;
        default:
        begin
          for (int w = 0; w < NW; w++)
          begin
            for (int s = 0; s < NS; s++)
            begin
              if (s_axi_araddr == msw_pkg::ADDR_CFG_BASE + 8'((w*NS+s)*4))
              begin
                s_axi_rdata <= {28'h0, wdt_en[w], stage_act[w][s]};
              end
              if (s_axi_araddr == msw_pkg::ADDR_TMO_BASE + 8'((w*NS+s)*4))
              begin
                s_axi_rdata <= stage_tmo[w][s];
              end
            end
          end
        end
      endcase
    end
    else
    begin
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    end
  end

endmodule

// file: msw_checker.sv
`timescale 1ns/1ns

// ----------------------------------------
// port checker
// ----------------------------------------
module msw_checker
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // actions
  input wire logic cpu_rst,
  input wire logic core_rst,
  input wire logic sys_rst
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cpu and core reset actions are one-cycle pulses
  property p_cpu_pulse; cpu_rst |=> !cpu_rst; endproperty
  a_cpu_pulse: assert property (p_cpu_pulse)
    else $error("cpu reset longer than one cycle");
  property p_core_pulse; core_rst |=> !core_rst; endproperty
  a_core_pulse: assert property (p_core_pulse)
    else $error("core reset longer than one cycle");
  // one action at a time per expiry
  property p_one_act; $onehot0({cpu_rst, core_rst, sys_rst}); endproperty
  a_one_act: assert property (p_one_act)
    else $error("two reset actions at once");
  // write response handshake
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write response repeated");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while response pending");
  // read data handshake
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data dropped before taken");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("read data late");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while data pending");
endmodule

bind msw_top msw_checker msw_checker_inst (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_rst,
  .core_rst, .sys_rst);

// file: multi_stage_watchdog_tb.sv
`timescale 1ns/1ns

module multi_stage_watchdog_tb;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic flash_boot = 1'b0;
  logic boot_done = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, cpu_rst, core_rst, sys_rst;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] outs;
  int fails = 0, checks_done = 0, ncpu = 0, ncore = 0, nsys = 0, n;

  msw_top msw_top_inst (.aclk, .aresetn, .flash_boot, .boot_done,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq, .cpu_rst, .core_rst, .sys_rst);

  // 25 MHz clock
  initial forever #20 aclk = ~aclk;

  // count action pulses
  assign outs = {sys_rst, core_rst, cpu_rst, irq};
  always @(posedge aclk)
  begin
    ncpu += (cpu_rst === 1'b1);
    ncore += (core_rst === 1'b1);
    nsys += (sys_rst === 1'b1);
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task rst(input logic fb);
    @(posedge aclk);
    aresetn <= 1'b0;
    flash_boot <= fb;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // bus write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw_ok = 1'b1;
      if (s_axi_wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // bus read, ready raised late so data must stand
  task rdw(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    rdw(a);
    chk(rd, exp);
  endtask

  // wait for output k: 0 irq, 1 cpu, 2 core, 3 sys
  task wt(input int k);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (outs[k] !== 1'b1 && n < 300);
    chk(n < 300, 1'b1);
  endtask

  function logic [7:0] ca(input int w, input int s);
    return msw_pkg::ADDR_CFG_BASE + 8'(4 * (w * 4 + s));
  endfunction

  function logic [7:0] ta(input int w, input int s);
    return msw_pkg::ADDR_TMO_BASE + 8'(4 * (w * 4 + s));
  endfunction

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    rst(1'b0);
    rdc(msw_pkg::ADDR_WPROT, 32'h0);
    rdc(ta(1, 2), msw_pkg::TMO_RESET);
    rdc(msw_pkg::ADDR_STATUS, 32'h0);
    rdc(8'h08, 32'h0);
    chk(rsp, msw_pkg::RESP_SLVERR);
    wr(8'h08, 32'h0);
    chk(rsp, msw_pkg::RESP_SLVERR);
    wr(ta(1, 0), 32'h14);
    rdc(ta(1, 0), msw_pkg::TMO_RESET);
    wr(msw_pkg::ADDR_WPROT, msw_pkg::WPROT_KEY);
    chk(rsp, msw_pkg::RESP_OKAY);
    rdc(msw_pkg::ADDR_WPROT, 32'h1);
    $display("end of test lock");
    // four stages of instance 1, interrupt masked
    for (int s = 0; s < 4; s++) wr(ta(1, s), 32'h14);
    rdc(ta(1, 3), 32'h14);
    wr(ca(1, 3), 32'(msw_pkg::ACT_SYS));
    wr(ca(1, 2), 32'(msw_pkg::ACT_CORE));
    wr(ca(1, 1), 32'(msw_pkg::ACT_CPU));
    wr(ca(1, 0), 32'h9);
    wt(1);
    chk(irq, 1'b0);
    chk(ncore + nsys, 0);
    wt(2);
    chk(n >= 20 && n <= 22, 1'b1);
    wt(2);
    chk(n >= 20 && n <= 22, 1'b1);
    chk(nsys, 0);
    rdc(msw_pkg::ADDR_IRQ_STAT, 32'h2);
    rdc(msw_pkg::ADDR_IRQ_STAT, 32'h0);
    wr(msw_pkg::ADDR_IRQ_MASK, 32'h2);
    wt(0);
    chk(n <= 25, 1'b1);
    rdw(msw_pkg::ADDR_IRQ_STAT);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(ca(1, 0), 32'h1);
    $display("end of test stages");
    // feeding holds off the cpu reset
    wr(ta(1, 0), 32'h1e);
    wr(ca(1, 0), 32'ha);
    ncpu = 0;
    repeat (10)
    begin
      wr(msw_pkg::ADDR_FEED, 32'h2);
      repeat (8) @(posedge aclk);
    end
    chk(ncpu, 0);
    wt(1);
    chk(n >= 22 && n <= 24, 1'b1);
    wr(ca(1, 0), 32'h2);
    $display("end of test feed");
    // system action only on the low-power instance
    for (int w = 0; w < 3; w += 2)
    begin
      wr(ta(w, 0), 32'ha);
      wr(ca(w, 0), 32'hc);
      wt(w == 2 ? 3 : 2);
      chk(n <= 15, 1'b1);
      wr(ca(w, 0), 32'h4);
      chk(nsys, w == 2);
    end
    $display("end of test actions");
    // flash boot auto start and boot guard
    rst(1'b1);
    rdw(msw_pkg::ADDR_STATUS);
    chk(rd & 32'h407, 32'h405);
    rdc(ca(2, 0), 32'hc);
    rdc(ca(0, 0), 32'ha);
    wr(msw_pkg::ADDR_WPROT, msw_pkg::WPROT_KEY);
    wr(msw_pkg::ADDR_BOOT, 32'h40);
    wt(3);
    chk(n <= 70, 1'b1);
    // boot finished: guard stops and system resets cease
    boot_done <= 1'b1;
    repeat (2) @(posedge aclk);
    n = nsys;
    rdw(msw_pkg::ADDR_STATUS);
    chk(rd & 32'h400, 32'h0);
    chk(nsys, n);
    $display("end of test boot");
    end_sim;
  end

  // tests need under 1000 cycles; stop a hang at 20000
  initial
  begin
    #(40 * 20000);
    fails++;
    end_sim;
  end
endmodule
